/* accumulator_stack_ops_bench.sv */
// Purpose: Directed self-checking bench for the stack, byte and pointer datapath.
// Assumes: Inputs change on the falling edge, results read one falling edge later.
// Notes: Stack contents are always built through loads, never read back as expectations.
`timescale 1ns/1ps
module accumulator_stack_ops_bench;
    logic core_clk, nrst, instr_valid, instr_done, instr_unknown;
    logic [15:0] instr_word;
    logic [31:0] instr_operand, wr1, wr2, wr3, wr4, ptr1, ptr2;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    aso_core dut_u (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_operand(instr_operand), .working_register_1(wr1),
        .working_register_2(wr2), .working_register_3(wr3), .working_register_4(wr4),
        .pointer_reg_one(ptr1), .pointer_reg_two(ptr2), .instr_done(instr_done),
        .instr_unknown(instr_unknown));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Hang guard, far above the fifty or so cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Present one word at a falling edge; valid stays high for back-to-back use
    task automatic put(input logic [7:0] op, input logic [7:0] imm, input logic [31:0] opd);
        instr_valid = 1'b1;
        instr_word = {op, imm};
        instr_operand = opd;
        @(negedge core_clk);
        check("done flags", {instr_done, instr_unknown}, {1'b1, op == 8'h0C});
    endtask

    // Builds a,b,c,d into entries four..one using loads and deepens only
    task automatic fill4(input logic [31:0] a, b, c, d);
        put(8'h06, 8'h00, a);
        put(8'h06, 8'h00, b);
        put(8'h01, 8'h00, 32'h0);
        put(8'h06, 8'h00, c);
        check("deepen before load", wr3, a);
        put(8'h01, 8'h00, 32'h0);
        put(8'h06, 8'h00, d);
    endtask

    task automatic t_stack();
        fill4(32'hA0A0A0A0, 32'hB1B1B1B1, 32'hC2C2C2C2, 32'hD3D3D3D3);
        check("filled stack", {wr1, wr2, wr3, wr4}, 128'hD3D3D3D3C2C2C2C2B1B1B1B1A0A0A0A0);
        put(8'h02, 8'h00, 32'h5A5A5A5A);
        check("stack raise", {wr1, wr2, wr3, wr4}, 128'hD3D3D3D3B1B1B1B1A0A0A0A0A0A0A0A0);
        fill4(32'h01020304, 32'h11121314, 32'h21222324, 32'h31323334);
        put(8'h07, 8'h00, 32'hE5E5E5E5);
        check("float result", {wr1, wr2, wr3, wr4}, 128'hE5E5E5E511121314010203040102030_4);
    endtask

    task automatic t_byte();
        logic [7:0] ops [4] = '{8'h03, 8'h04, 8'h04, 8'h03};
        logic [7:0] imms [4] = '{8'h05, 8'h10, 8'hFF, 8'hFF};
        logic [7:0] res [4] = '{8'h03, 8'hF3, 8'hF4, 8'hF3};
        put(8'h06, 8'h00, 32'h0000FFFF);
        put(8'h06, 8'h00, 32'h123456FE);
        for (int k = 0; k < 4; k++) begin
            put(ops[k], imms[k], 32'hFFFFFFFF);
            check("lowest byte", {wr1, wr2}, {24'h123456, res[k], 32'h0000FFFF});
        end
    endtask

    task automatic t_ptr();
        logic [31:0] opd [4] = '{32'h0000FFFF, 32'hFFFF0001, 32'hABCD8000, 32'h00007FFF};
        logic [31:0] pexp [4] = '{32'h00FFFFFF, 32'h00000000, 32'h00FF8000, 32'h00FFFFFF};
        logic [7:0] base;
        for (int i = 0; i < 2; i++) begin
            base = (i == 1) ? 8'h0A : 8'h08;
            for (int k = 0; k < 4; k++) begin
                if (k < 2) begin
                    put(base + 8'h01, 8'h00, opd[k]);
                end else begin
                    put(8'h06, 8'h00, opd[k]);
                    put(base, 8'h00, 32'h0);
                end
                check("pointer add", {ptr1, ptr2}, (i == 1) ? {32'h00FFFFFF, pexp[k]} : {pexp[k], 32'h0});
            end
        end
    endtask

    task automatic t_null();
        logic [15:0] words [6] = '{16'h0000, 16'hFFFF, 16'h0500, 16'h05FF, 16'h00AB, 16'h0C00};
        fill4(32'h44444444, 32'h55555555, 32'h66666666, 32'h77777777);
        for (int k = 0; k < 6; k++) begin
            put(words[k][15:8], words[k][7:0], 32'hDEADBEEF);
            check("null words", {wr1, wr2, wr3, wr4, ptr1, ptr2}, {128'h77777777666666665555555544444444, 64'h00FFFFFF00FFFFFF});
        end
    endtask

    // Main sequence: reset, then the scenarios back to back
    initial begin
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        instr_operand = 32'h0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        check("reset values", {wr1, wr2, wr3, wr4, ptr1, ptr2}, 192'h0);
        t_stack();
        t_byte();
        t_ptr();
        t_null();
        instr_valid = 1'b0;
        @(negedge core_clk);
        check("idle flags", {instr_done, instr_unknown}, 2'b00);
        // Mid-run reset clears the stack at once; first word right after release
        nrst = 1'b0;
        @(negedge core_clk);
        check("mid-run reset", {wr1, wr2, wr3, wr4, ptr1, ptr2}, 192'h0);
        nrst = 1'b1;
        put(8'h06, 8'h00, 32'h13579BDF);
        check("load after reset", {wr1, wr2}, 64'h13579BDF00000000);
        instr_valid = 1'b0;
        give_verdict();
    end
endmodule

/* aso_core.sv */
// Purpose: Execute stack moves, lowest-byte add and subtract, and pointer offset adds.
// Assumes: Every valid instruction completes in the cycle it is taken.
// Notes: Status word lives outside this block and is never touched from here.
`timescale 1ns/1ps
module aso_core (
    input wire logic core_clk, // 250 MHz core clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic instr_valid, // Instruction word present this cycle
    input wire logic [15:0] instr_word, // Opcode high byte, immediate low byte
    input wire logic [31:0] instr_operand, // Load data, float result or pointer constant
    output logic [31:0] working_register_1, // Top of the working stack
    output logic [31:0] working_register_2, // Second stack entry
    output logic [31:0] working_register_3, // Third stack entry
    output logic [31:0] working_register_4, // Bottom stack entry
    output logic [31:0] pointer_reg_one, // Address register one
    output logic [31:0] pointer_reg_two, // Address register two
    output logic instr_done, // Pulse one cycle after a valid word
    output logic instr_unknown // Pulse for an undefined opcode
);

    logic [31:0] wr1_reg;
    logic [31:0] wr2_reg;
    logic [31:0] wr3_reg;
    logic [31:0] wr4_reg;
    logic [31:0] ptr1_reg;
    logic [31:0] ptr2_reg;
    logic done_reg;
    logic unknown_reg;

    logic [31:0] wr1_next;
    logic [31:0] wr2_next;
    logic [31:0] wr3_next;
    logic [31:0] wr4_next;
    logic [31:0] ptr1_next;
    logic [31:0] ptr2_next;
    logic unknown_next;

    logic [7:0] opc;
    logic [7:0] imm_byte;
    logic is_null_word;
    logic [7:0] wr1_lowest_byte;
    logic [15:0] wr1_low_half;
    logic [7:0] byte_sum;
    logic [7:0] byte_diff;
    logic [15:0] reg_offset;
    logic [15:0] imm_offset;
    logic [23:0] reg_offset_ext;
    logic [23:0] imm_offset_ext;

    // Field split of the instruction word
    assign opc = instr_word[aso_pkg::OPC_LSB +: aso_pkg::OPC_W];
    assign imm_byte = instr_word[aso_pkg::IMM_W-1:0];

    // Whole-word null patterns win over any opcode decode
    assign is_null_word = (instr_word == aso_pkg::WORD_ALL_ZERO) ||
                          (instr_word == aso_pkg::WORD_ALL_ONES);

    // Byte arithmetic is 8 bits wide, so carry and borrow fall off
    assign wr1_lowest_byte = wr1_reg[aso_pkg::IMM_W-1:0];
    assign byte_sum = wr1_lowest_byte + imm_byte;
    assign byte_diff = wr1_lowest_byte - imm_byte;

    // Offsets: register form from low half, immediate from the pointer constant
    assign wr1_low_half = wr1_reg[aso_pkg::HALF_W-1:0];
    assign reg_offset = wr1_low_half;
    assign imm_offset = instr_operand[aso_pkg::OFFS_W-1:0];

    // Sign extension to the relative address width
    assign reg_offset_ext = {{(aso_pkg::REL_W-aso_pkg::OFFS_W){reg_offset[aso_pkg::OFFS_W-1]}},
                             reg_offset};
    assign imm_offset_ext = {{(aso_pkg::REL_W-aso_pkg::OFFS_W){imm_offset[aso_pkg::OFFS_W-1]}},
                             imm_offset};

    // Pointer add keeps the top byte, area field included
    function automatic logic [31:0] ptr_add(input logic [31:0] ptr, input logic [23:0] offs);
        logic [23:0] rel;
        rel = ptr[aso_pkg::REL_W-1:0] + offs;
        ptr_add = {ptr[aso_pkg::WORD_W-1:aso_pkg::REL_W], rel};
    endfunction

    // Next value of the top working register
    always_comb begin
        wr1_next = wr1_reg;
        if (instr_valid && !is_null_word) begin
            case (opc)
                aso_pkg::ASO_OP_LOAD: begin
                    wr1_next = instr_operand;
                end
                aso_pkg::ASO_OP_FLOAT: begin
                    wr1_next = instr_operand;
                end
                aso_pkg::ASO_OP_BYTE_ADD: begin
                    wr1_next = {wr1_reg[aso_pkg::WORD_W-1:aso_pkg::IMM_W], byte_sum};
                end
                aso_pkg::ASO_OP_BYTE_SUB: begin
                    wr1_next = {wr1_reg[aso_pkg::WORD_W-1:aso_pkg::IMM_W], byte_diff};
                end
                default: begin
                    wr1_next = wr1_reg;
                end
            endcase
        end
    end

    // Next value of the second working register
    always_comb begin
        wr2_next = wr2_reg;
        if (instr_valid && !is_null_word) begin
            case (opc)
                aso_pkg::ASO_OP_LOAD: begin
                    wr2_next = wr1_reg;
                end
                aso_pkg::ASO_OP_RAISE: begin
                    wr2_next = wr3_reg;
                end
                aso_pkg::ASO_OP_FLOAT: begin
                    wr2_next = wr3_reg;
                end
                default: begin
                    wr2_next = wr2_reg;
                end
            endcase
        end
    end

    // Next value of the third working register
    always_comb begin
        wr3_next = wr3_reg;
        if (instr_valid && !is_null_word) begin
            case (opc)
                aso_pkg::ASO_OP_DEEPEN: begin
                    // A following load leaves this copy alone
                    wr3_next = wr2_reg;
                end
                aso_pkg::ASO_OP_RAISE: begin
                    wr3_next = wr4_reg;
                end
                aso_pkg::ASO_OP_FLOAT: begin
                    wr3_next = wr4_reg;
                end
                default: begin
                    wr3_next = wr3_reg;
                end
            endcase
        end
    end

    // Next value of the bottom working register
    always_comb begin
        wr4_next = wr4_reg;
        if (instr_valid && !is_null_word) begin
            case (opc)
                aso_pkg::ASO_OP_DEEPEN: begin
                    wr4_next = wr3_reg;
                end
                default: begin
                    wr4_next = wr4_reg;
                end
            endcase
        end
    end

    // Next values of both address registers
    always_comb begin
        ptr1_next = ptr1_reg;
        ptr2_next = ptr2_reg;
        if (instr_valid && !is_null_word) begin
            case (opc)
                aso_pkg::ASO_OP_PTR1_REG: begin
                    ptr1_next = ptr_add(ptr1_reg, reg_offset_ext);
                end
                aso_pkg::ASO_OP_PTR1_IMM: begin
                    ptr1_next = ptr_add(ptr1_reg, imm_offset_ext);
                end
                aso_pkg::ASO_OP_PTR2_REG: begin
                    ptr2_next = ptr_add(ptr2_reg, reg_offset_ext);
                end
                aso_pkg::ASO_OP_PTR2_IMM: begin
                    ptr2_next = ptr_add(ptr2_reg, imm_offset_ext);
                end
                default: begin
                    ptr1_next = ptr1_reg;
                    ptr2_next = ptr2_reg;
                end
            endcase
        end
    end

    // Undefined opcodes are flagged but change nothing
    always_comb begin
        unknown_next = 1'b0;
        if (instr_valid && !is_null_word) begin
            case (opc)
                aso_pkg::ASO_OP_NULL_ZEROS,
                aso_pkg::ASO_OP_DEEPEN,
                aso_pkg::ASO_OP_RAISE,
                aso_pkg::ASO_OP_BYTE_ADD,
                aso_pkg::ASO_OP_BYTE_SUB,
                aso_pkg::ASO_OP_MARKER,
                aso_pkg::ASO_OP_LOAD,
                aso_pkg::ASO_OP_FLOAT,
                aso_pkg::ASO_OP_PTR1_REG,
                aso_pkg::ASO_OP_PTR1_IMM,
                aso_pkg::ASO_OP_PTR2_REG,
                aso_pkg::ASO_OP_PTR2_IMM,
                aso_pkg::ASO_OP_NULL_ONES: begin
                    unknown_next = 1'b0;
                end
                default: begin
                    unknown_next = 1'b1;
                end
            endcase
        end
    end

    // Top working register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr1_reg <= aso_pkg::WR_RESET;
        end else begin
            wr1_reg <= wr1_next;
        end
    end

    // Second working register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr2_reg <= aso_pkg::WR_RESET;
        end else begin
            wr2_reg <= wr2_next;
        end
    end

    // Third working register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr3_reg <= aso_pkg::WR_RESET;
        end else begin
            wr3_reg <= wr3_next;
        end
    end

    // Bottom working register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr4_reg <= aso_pkg::WR_RESET;
        end else begin
            wr4_reg <= wr4_next;
        end
    end

    // Address register one; no status flags from the add, by design
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ptr1_reg <= aso_pkg::PTR_RESET;
        end else begin
            ptr1_reg <= ptr1_next;
        end
    end

    // Address register two
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ptr2_reg <= aso_pkg::PTR_RESET;
        end else begin
            ptr2_reg <= ptr2_next;
        end
    end

    // Completion and undefined-opcode pulses
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            done_reg <= 1'b0;
            unknown_reg <= 1'b0;
        end else begin
            done_reg <= instr_valid;
            unknown_reg <= unknown_next;
        end
    end

    // Outputs straight from flip-flops
    assign working_register_1 = wr1_reg;
    assign working_register_2 = wr2_reg;
    assign working_register_3 = wr3_reg;
    assign working_register_4 = wr4_reg;
    assign pointer_reg_one = ptr1_reg;
    assign pointer_reg_two = ptr2_reg;
    assign instr_done = done_reg;
    assign instr_unknown = unknown_reg;

endmodule

/* aso_core_sva.sv */
// Purpose: Concurrent checks on the stack, byte and pointer datapath ports.
// Assumes: Opcode bytes as declared in the shared package, one word per cycle.
// Notes: Status word is outside the block, so status-bit rules are not visible here.
`timescale 1ns/1ps
module aso_core_chk (
    input wire logic core_clk, // Core clock
    input wire logic nrst, // Async reset, active low
    input wire logic instr_valid, // Word present
    input wire logic [15:0] instr_word, // Opcode and immediate
    input wire logic [31:0] instr_operand, // Side operand
    input wire logic [31:0] working_register_1, // Stack top
    input wire logic [31:0] working_register_2, // Stack second
    input wire logic [31:0] working_register_3, // Stack third
    input wire logic [31:0] working_register_4, // Stack bottom
    input wire logic [31:0] pointer_reg_one, // Address register one
    input wire logic [31:0] pointer_reg_two, // Address register two
    input wire logic instr_done, // Done pulse
    input wire logic instr_unknown // Unknown opcode pulse
);
    logic [7:0] opc;
    logic [31:0] w1, w2, w3, w4, p1, p2;
    logic [23:0] sr1, si1, sr2, si2;
    // Short aliases keep the properties readable
    assign opc = instr_word[15:8];
    assign w1 = working_register_1;
    assign w2 = working_register_2;
    assign w3 = working_register_3;
    assign w4 = working_register_4;
    assign p1 = pointer_reg_one;
    assign p2 = pointer_reg_two;
    // Expected low 24 bits; the carry out of bit 23 is dropped on purpose
    assign sr1 = p1[23:0] + {{8{w1[15]}}, w1[15:0]};
    assign si1 = p1[23:0] + {{8{instr_operand[15]}}, instr_operand[15:0]};
    assign sr2 = p2[23:0] + {{8{w1[15]}}, w1[15:0]};
    assign si2 = p2[23:0] + {{8{instr_operand[15]}}, instr_operand[15:0]};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence take(logic [7:0] code);
        instr_valid && opc == code;
    endsequence
    sequence deepen_then_load;
        take(8'h01) ##1 take(8'h06);
    endsequence

    deepen_move_a: assert property (take(8'h01) |=>
        w4 == $past(w3) && w3 == $past(w2) && $stable(w1) && $stable(w2))
        else $error("stack deepen moved wrong values");
    raise_move_a: assert property (take(8'h02) |=>
        w2 == $past(w3) && w3 == $past(w4) && $stable(w1) && $stable(w4))
        else $error("stack raise moved wrong values");
    deepen_load_keep_a: assert property (deepen_then_load |=> w3 == $past(w2, 2))
        else $error("intermediate value lost from third entry");
    load_move_a: assert property (take(8'h06) |=>
        w2 == $past(w1) && w1 == $past(instr_operand))
        else $error("load moved wrong values");
    float_move_a: assert property (take(8'h07) |=>
        w1 == $past(instr_operand) && w2 == $past(w3) && w3 == $past(w4) && $stable(w4))
        else $error("float result placement wrong");
    byte_add_a: assert property (take(8'h03) |=>
        w1 == {$past(w1[31:8]), 8'($past(w1[7:0] + instr_word[7:0]))} && $stable(w2))
        else $error("lowest byte add wrong");
    byte_sub_a: assert property (take(8'h04) |=>
        w1 == {$past(w1[31:8]), 8'($past(w1[7:0] - instr_word[7:0]))} && $stable(w2))
        else $error("lowest byte subtract wrong");
    ptr_one_reg_a: assert property (take(8'h08) |=>
        p1 == {$past(p1[31:24]), $past(sr1)} && $stable(p2))
        else $error("pointer one register add wrong");
    ptr_one_imm_a: assert property (take(8'h09) |=>
        p1 == {$past(p1[31:24]), $past(si1)} && $stable(p2))
        else $error("pointer one immediate add wrong");
    ptr_two_reg_a: assert property (take(8'h0A) |=>
        p2 == {$past(p2[31:24]), $past(sr2)} && $stable(p1))
        else $error("pointer two register add wrong");
    ptr_two_imm_a: assert property (take(8'h0B) |=>
        p2 == {$past(p2[31:24]), $past(si2)} && $stable(p1))
        else $error("pointer two immediate add wrong");
    null_hold_a: assert property (instr_valid && (opc == 8'h00 || opc == 8'h05 ||
        opc == 8'hFF) |=> $stable({w1, w2, w3, w4, p1, p2}))
        else $error("null or marker word changed a register");
    // Completion pulse follows every taken word by exactly one cycle
    done_pulse_a: assert property (instr_done == $past(instr_valid))
        else $error("completion pulse out of step with taken words");
    // Only opcodes 8'h0C to 8'hFE raise the undefined flag
    unknown_flag_a: assert property (instr_unknown == $past(instr_valid &&
        instr_word != 16'hFFFF && opc > 8'h0B && opc != 8'hFF))
        else $error("undefined opcode flag wrong");
endmodule

bind aso_core aso_core_chk chk_u (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_operand(instr_operand),
    .working_register_1(working_register_1), .working_register_2(working_register_2),
    .working_register_3(working_register_3), .working_register_4(working_register_4),
    .pointer_reg_one(pointer_reg_one), .pointer_reg_two(pointer_reg_two),
    .instr_done(instr_done), .instr_unknown(instr_unknown));

/* aso_pkg.sv */
// Purpose: Shared constants and opcode encoding for the accumulator stack datapath.
// Assumes: One instruction word per cycle, opcode in the high byte, immediate in the low byte.
// Notes: Load data, float results and pointer constants arrive on a separate operand port.
// Notes on behaviour
// - Stack deepen copies register three to four and two to three.
// - Stack raise copies register three to two and four to three.
// - Deepen before a load keeps the earlier intermediate value in register three.
// - Load moves register one to two, then puts fetched value in one.
// - Float two-operand op writes one, moves three to two, four to three.
// - Byte add puts lowest byte of register one plus constant back there.
// - Byte subtract puts lowest byte of register one minus constant back there.
// - No carry or borrow beyond lowest byte; upper bytes and register two stay.
// - Stack moves, byte ops and pointer adds ignore and keep status bits.
// - Pointer one add sign-extends a 16-bit offset to 24 bits, adds low bits.
// - Area field bits 24 to 26 of the pointer stay unchanged.
// - Register form takes signed offset from low half of register one.
// - Immediate form takes offset from the pointer constant in the instruction.
// - Pointer two add works the same, both register and immediate forms.
// - Display marker carries a number 0 to 255 and does nothing.
// - All-zero instruction word is a null operation.
// - All-ones instruction word is a second null operation.
package aso_pkg;

    localparam int unsigned WORD_W = 32;
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned OPC_W = 8;
    localparam int unsigned IMM_W = 8;
    localparam int unsigned OFFS_W = 16;
    localparam int unsigned REL_W = 24;
    localparam int unsigned OPC_LSB = 8;
    localparam int unsigned HALF_W = 16;

    localparam logic [WORD_W-1:0] WR_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] PTR_RESET = 32'h0000_0000;
    localparam logic [INSTR_W-1:0] WORD_ALL_ZERO = 16'h0000;
    localparam logic [INSTR_W-1:0] WORD_ALL_ONES = 16'hFFFF;

    // Opcode byte of the instruction word
    typedef enum logic [OPC_W-1:0] {
        ASO_OP_NULL_ZEROS = 8'h00,
        ASO_OP_DEEPEN = 8'h01,
        ASO_OP_RAISE = 8'h02,
        ASO_OP_BYTE_ADD = 8'h03,
        ASO_OP_BYTE_SUB = 8'h04,
        ASO_OP_MARKER = 8'h05,
        ASO_OP_LOAD = 8'h06,
        ASO_OP_FLOAT = 8'h07,
        ASO_OP_PTR1_REG = 8'h08,
        ASO_OP_PTR1_IMM = 8'h09,
        ASO_OP_PTR2_REG = 8'h0A,
        ASO_OP_PTR2_IMM = 8'h0B,
        ASO_OP_NULL_ONES = 8'hFF
    } aso_op_e;

endpackage
